// *** verilog/scmfc_top.sv ***
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Synchronous mode: eight data bits, nothing more.
// - Synchronous receive flags only the overrun error.
// - Synchronous internal clock: generator drives clock pin.
// - Synchronous external clock: shift on pin clock.
// - Mode bit 7 and clock bits pick source.
// - Bits 6,5,3 pick length, parity, stop count.
// - Multiprocessor bit replaces parity; sync ignores format.
// - Asynchronous, both clock bits clear: pin unused.
// - Asynchronous clock output runs at the bit rate.
// - Asynchronous receive flags framing, parity, overrun, break.
module scmfc_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [scmfc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [scmfc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sck_pin,
  output logic sck_drive,
  output logic sck_drive_en,
  input wire logic rx_overrun,
  input wire logic rx_framing,
  input wire logic rx_parity,
  input wire logic rx_break,
  output logic irq,
  output logic fmt_sync,
  output logic [3:0] fmt_data_bits,
  output logic fmt_parity,
  output logic fmt_mpb,
  output logic [1:0] fmt_stop_bits,
  output logic tick16,
  output logic bit_tick
);
  import scmfc_pkg::*;

  // ********************************
  // State
  // ********************************
  logic sck_s1_reg;
  logic sck_s2_reg;
  logic [7:0] mode_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] div_reg;
  logic [EV_W-1:0] stat_reg;
  logic [EV_W-1:0] stat_next;
  logic [EV_W-1:0] ien_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic fmt_sync_reg;
  logic [3:0] fmt_bits_reg;
  logic fmt_par_reg;
  logic fmt_mpb_reg;
  logic [1:0] fmt_stop_reg;
  logic tick16_reg;
  logic bit_tick_reg;

  scmfc_clk_if cif ();

  scmfc_clkgen u_clkgen (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .cif(cif.gen)
  );

  // ********************************
  // Format and clock source decode
  // ********************************
  wire sync_mode = mode_reg[MODE_SYNC];
  wire async_mode = ~sync_mode;
  // Synchronous mode overrides every format bit, so they are don't-care there.
  wire [3:0] bits_w = (sync_mode | ~mode_reg[MODE_CHR]) ? DATA8 : DATA7;
  wire mpb_w = async_mode & mode_reg[MODE_MP];
  wire par_w = async_mode & mode_reg[MODE_PE] & ~mode_reg[MODE_MP];
  wire [1:0] stop_w = sync_mode ? STOP0 : (mode_reg[MODE_STOP] ? STOP2 : STOP1);

  assign cif.sync_mode = sync_mode;
  assign cif.clock_enable_1 = ctrl_reg[CTRL_CLOCK_ENABLE_1];
  assign cif.clock_enable_0 = ctrl_reg[CTRL_CLOCK_ENABLE_0];
  assign cif.divisor = div_reg;
  assign cif.sck_lvl = sck_s2_reg;

  // ********************************
  // Register bus decode
  // ********************************
  // Address and data are taken together in one cycle; a lone one waits.
  wire wr_go = ce & s_axi_awvalid & s_axi_wvalid & ~bvalid_reg;
  wire wr_lane = wr_go & s_axi_wstrb[0];
  wire wr_mode = wr_lane & (s_axi_awaddr == OFF_MODE);
  wire wr_ctrl = wr_lane & (s_axi_awaddr == OFF_CTRL);
  wire wr_div = wr_lane & (s_axi_awaddr == OFF_DIV);
  wire wr_clr = wr_lane & (s_axi_awaddr == OFF_CLR);
  wire wr_ien = wr_lane & (s_axi_awaddr == OFF_IEN);
  wire wr_hit = (s_axi_awaddr == OFF_MODE) | (s_axi_awaddr == OFF_CTRL)
              | (s_axi_awaddr == OFF_DIV) | (s_axi_awaddr == OFF_STAT)
              | (s_axi_awaddr == OFF_CLR) | (s_axi_awaddr == OFF_IEN)
              | (s_axi_awaddr == OFF_FMT);
  wire rd_go = ce & s_axi_arvalid & ~rvalid_reg;
  wire [31:0] fmt_word = {22'h0, sck_drive_en, fmt_sync_reg, fmt_mpb_reg,
                          fmt_par_reg, fmt_stop_reg, fmt_bits_reg};
  wire rd_hit = (s_axi_araddr == OFF_MODE) | (s_axi_araddr == OFF_CTRL)
              | (s_axi_araddr == OFF_DIV) | (s_axi_araddr == OFF_STAT)
              | (s_axi_araddr == OFF_CLR) | (s_axi_araddr == OFF_IEN)
              | (s_axi_araddr == OFF_FMT);
  // The clear register is write-only and reads back as zero.
  wire [31:0] rd_val =
    (s_axi_araddr == OFF_MODE) ? {24'h000000, mode_reg} :
    (s_axi_araddr == OFF_CTRL) ? {24'h000000, ctrl_reg} :
    (s_axi_araddr == OFF_DIV) ? {24'h000000, div_reg} :
    (s_axi_araddr == OFF_STAT) ? {28'h0000000, stat_reg} :
    (s_axi_araddr == OFF_IEN) ? {28'h0000000, ien_reg} :
    (s_axi_araddr == OFF_FMT) ? fmt_word : 32'h00000000;

  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = rd_go;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

  // ********************************
  // Receive error events
  // ********************************
  // Overrun is the only error a synchronous frame can carry.
  wire [EV_W-1:0] ev_set = {rx_break & async_mode, rx_parity & par_w,
                            rx_framing & async_mode, rx_overrun};
  wire [EV_W-1:0] ev_clr = wr_clr ? s_axi_wdata[EV_W-1:0] : EV_NONE;
  // A set in the same cycle as its clear survives.
  assign stat_next = (stat_reg & ~ev_clr) | ev_set;
  assign irq = |(stat_reg & ien_reg);

  assign sck_drive = cif.sck_drv;
  assign sck_drive_en = cif.sck_drv_en;
  assign fmt_sync = fmt_sync_reg;
  assign fmt_data_bits = fmt_bits_reg;
  assign fmt_parity = fmt_par_reg;
  assign fmt_mpb = fmt_mpb_reg;
  assign fmt_stop_bits = fmt_stop_reg;
  assign tick16 = tick16_reg;
  assign bit_tick = bit_tick_reg;

  // ********************************
  // Registers
  // ********************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_s1_reg <= 1'b1;
      sck_s2_reg <= 1'b1;
    end else if (ce) begin
      sck_s1_reg <= sck_pin;
      sck_s2_reg <= sck_s1_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= MODE_RST;
      ctrl_reg <= CTRL_RST;
      div_reg <= DIV_RST;
      ien_reg <= EV_NONE;
      stat_reg <= EV_NONE;
    end else if (ce) begin
      if (wr_mode) mode_reg <= s_axi_wdata[7:0];
      if (wr_ctrl) ctrl_reg <= s_axi_wdata[7:0];
      if (wr_div) div_reg <= s_axi_wdata[7:0];
      if (wr_ien) ien_reg <= s_axi_wdata[EV_W-1:0];
      stat_reg <= stat_next;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fmt_sync_reg <= 1'b0;
      fmt_bits_reg <= DATA8;
      fmt_par_reg <= 1'b0;
      fmt_mpb_reg <= 1'b0;
      fmt_stop_reg <= STOP1;
      tick16_reg <= 1'b0;
      bit_tick_reg <= 1'b0;
    end else if (ce) begin
      fmt_sync_reg <= sync_mode;
      fmt_bits_reg <= bits_w;
      fmt_par_reg <= par_w;
      fmt_mpb_reg <= mpb_w;
      fmt_stop_reg <= stop_w;
      tick16_reg <= cif.tick16;
      bit_tick_reg <= cif.bit_tick;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h00000000;
    end else if (ce) begin
      if (wr_go) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
      if (rd_go) begin
        rvalid_reg <= 1'b1;
        rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        rdata_reg <= rd_val;
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // ********************************
  // Checks
  // ********************************
  // Helper: counts sixteenth-bit ticks between rises of the output clock.
  logic sck_q_reg;
  logic armed_reg;
  logic [4:0] t16_cnt_reg;
  wire drv_rise = cif.sck_drv & ~sck_q_reg;
  wire cfg_chg = wr_mode | wr_ctrl | wr_div;
  wire async_clkout = async_mode & ~cif.clock_enable_1 & cif.clock_enable_0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_q_reg <= 1'b1;
      armed_reg <= 1'b0;
      t16_cnt_reg <= 5'h00;
    end else if (ce) begin
      sck_q_reg <= cif.sck_drv;
      if (cfg_chg) armed_reg <= 1'b0;
      else if (drv_rise) armed_reg <= 1'b1;
      if (drv_rise) t16_cnt_reg <= {4'h0, cif.tick16};
      else if (cif.tick16) t16_cnt_reg <= t16_cnt_reg + 5'h01;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_sync_fixed;
    ce && sync_mode |=> fmt_data_bits == DATA8 && !fmt_parity && !fmt_mpb && fmt_stop_bits == STOP0;
  endproperty
  a_sync_fixed: assert property (p_sync_fixed) else $error("sync format not fixed");

  property p_sync_ovr_only;
    ce && sync_mode && rx_framing && !stat_reg[EV_FRM] |=> !stat_reg[EV_FRM];
  endproperty
  a_sync_ovr_only: assert property (p_sync_ovr_only) else $error("framing flagged in sync");

  property p_sync_int_drive;
    ce && sync_mode && !cif.clock_enable_1 |=> sck_drive_en;
  endproperty
  a_sync_int_drive: assert property (p_sync_int_drive) else $error("sync clock not driven");

  property p_ext_released;
    ce && $past(ce) && cif.clock_enable_1 |-> (!(cif.tick16 || cif.bit_tick) || $rose(sck_s2_reg)) ##1 !sck_drive_en;
  endproperty
  a_ext_released: assert property (p_ext_released) else $error("pin driven with external clock");

  property p_mode_bit;
    ce && !mode_reg[MODE_SYNC] |=> !fmt_sync;
  endproperty
  a_mode_bit: assert property (p_mode_bit) else $error("async mode reported sync");

  property p_char7;
    ce && async_mode && mode_reg[MODE_CHR] |=> fmt_data_bits == DATA7;
  endproperty
  a_char7: assert property (p_char7) else $error("seven-bit length not chosen");

  property p_mp_no_par;
    ce && async_mode && mode_reg[MODE_MP] |=> fmt_mpb && !fmt_parity;
  endproperty
  a_mp_no_par: assert property (p_mp_no_par) else $error("parity with multiprocessor bit");

  property p_async_unused;
    ce && async_mode && !cif.clock_enable_1 && !cif.clock_enable_0 |=> !sck_drive_en;
  endproperty
  a_async_unused: assert property (p_async_unused) else $error("pin used in plain async");

  property p_async_clkout;
    ce && armed_reg && drv_rise && async_clkout && !cfg_chg |-> t16_cnt_reg == TICKS_PER_BIT;
  endproperty
  a_async_clkout: assert property (p_async_clkout) else $error("output clock not at bit rate");

  property p_ext16;
    ce && $past(ce) && async_mode && cif.clock_enable_1 && $rose(sck_s2_reg) |-> cif.tick16;
  endproperty
  a_ext16: assert property (p_ext16) else $error("pin edge not a sixteenth tick");

  property p_err_set;
    ce && async_mode && rx_framing |=> stat_reg[EV_FRM] ##1 (stat_reg[EV_FRM] || $past(wr_clr && s_axi_wdata[EV_FRM]));
  endproperty
  a_err_set: assert property (p_err_set) else $error("framing error lost");

  property p_both_ext;
    ce && $past(ce) && sync_mode && cif.clock_enable_1 && cif.clock_enable_0 && $rose(sck_s2_reg) |-> cif.bit_tick;
  endproperty
  a_both_ext: assert property (p_both_ext) else $error("both bits not external");

  c_async_out: cover property (ce && async_clkout && drv_rise && armed_reg);
  c_sync_ext: cover property (ce && sync_mode && cif.clock_enable_1 && cif.bit_tick);
  c_ovr_irq: cover property (ce && rx_overrun && ien_reg[EV_OVR] ##1 irq);
  c_set_clr: cover property (ce && wr_clr && s_axi_wdata[EV_FRM] && rx_framing && async_mode);
endmodule
`default_nettype wire

// *** verilog/scmfc_pkg.sv ***
`default_nettype none
// ********************************
// Register map and field layout
// ********************************
package scmfc_pkg;
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFF_MODE = 5'h00;
  localparam logic [4:0] OFF_CTRL = 5'h04;
  localparam logic [4:0] OFF_DIV = 5'h08;
  localparam logic [4:0] OFF_STAT = 5'h0c;
  localparam logic [4:0] OFF_CLR = 5'h10;
  localparam logic [4:0] OFF_IEN = 5'h14;
  localparam logic [4:0] OFF_FMT = 5'h18;
  localparam int MODE_SYNC = 7;
  localparam int MODE_CHR = 6;
  localparam int MODE_PE = 5;
  localparam int MODE_STOP = 3;
  localparam int MODE_MP = 2;
  localparam int CTRL_CLOCK_ENABLE_1 = 1;
  localparam int CTRL_CLOCK_ENABLE_0 = 0;
  localparam int EV_OVR = 0;
  localparam int EV_FRM = 1;
  localparam int EV_PAR = 2;
  localparam int EV_BRK = 3;
  localparam int EV_W = 4;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DIV_RST = 8'h0f;
  localparam logic [EV_W-1:0] EV_NONE = 4'h0;
  localparam logic [3:0] DATA8 = 4'h8;
  localparam logic [3:0] DATA7 = 4'h7;
  localparam logic [1:0] STOP0 = 2'h0;
  localparam logic [1:0] STOP1 = 2'h1;
  localparam logic [1:0] STOP2 = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] PHASE_LAST = 4'hf;
  localparam int PHASE_MSB = 3;
  localparam logic [4:0] TICKS_PER_BIT = 5'h10;
endpackage
`default_nettype wire

// *** verilog/scmfc_clk_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface scmfc_clk_if;
  logic sync_mode;
  logic clock_enable_1;
  logic clock_enable_0;
  logic [7:0] divisor;
  logic sck_lvl;
  logic tick16;
  logic bit_tick;
  logic sck_drv;
  logic sck_drv_en;
  modport ctl (output sync_mode, clock_enable_1, clock_enable_0, divisor, sck_lvl,
               input tick16, bit_tick, sck_drv, sck_drv_en);
  modport gen (input sync_mode, clock_enable_1, clock_enable_0, divisor, sck_lvl,
               output tick16, bit_tick, sck_drv, sck_drv_en);
endinterface
`default_nettype wire

// *** verilog/scmfc_clkgen.sv ***
`timescale 1ns/10ps
`default_nettype none
module scmfc_clkgen (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  scmfc_clk_if.gen cif
);
  import scmfc_pkg::*;

  logic [7:0] brg_cnt_reg;
  logic [7:0] brg_cnt_next;
  logic [3:0] phase_reg;
  logic [3:0] phase_next;
  logic sck_prev_reg;
  logic sck_reg;
  logic sck_next;
  logic sck_en_reg;
  logic sck_en_next;

  // Any set clock_enable_1 means the pin clock, so both bits set act as clock_enable_1 alone: 1x in sync, 16x in async.
  wire use_brg = ~cif.clock_enable_1;
  // A compare rather than equality lets a smaller divisor take effect at once.
  wire brg_tick = ce & use_brg & (brg_cnt_reg >= cif.divisor);
  wire ext_rise = ce & cif.clock_enable_1 & cif.sck_lvl & ~sck_prev_reg;
  wire sync_rise = use_brg ? (brg_tick & ~sck_reg) : ext_rise;

  assign brg_cnt_next = (brg_tick | ~use_brg) ? 8'h00 : brg_cnt_reg + 8'h01;
  // Pin clock edges count as sixteenth-bit ticks in asynchronous mode.
  assign cif.tick16 = ~cif.sync_mode & (use_brg ? brg_tick : ext_rise);
  assign phase_next = cif.tick16 ? phase_reg + 4'h1 : phase_reg;
  assign cif.bit_tick = cif.sync_mode ? sync_rise : (cif.tick16 & (phase_reg == PHASE_LAST));
  // Phase MSB rises mid-bit, putting the output clock edge at the bit centre.
  assign sck_next = cif.sync_mode ? (sck_reg ^ brg_tick) : phase_next[PHASE_MSB];
  assign sck_en_next = use_brg & (cif.sync_mode | cif.clock_enable_0);
  assign cif.sck_drv = sck_reg;
  assign cif.sck_drv_en = sck_en_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      brg_cnt_reg <= 8'h00;
      phase_reg <= 4'h0;
      sck_prev_reg <= 1'b1;
      sck_reg <= 1'b1;
      sck_en_reg <= 1'b0;
    end else if (ce) begin
      brg_cnt_reg <= brg_cnt_next;
      phase_reg <= phase_next;
      sck_prev_reg <= cif.sck_lvl;
      sck_reg <= sck_next;
      sck_en_reg <= sck_en_next;
    end
  end
endmodule
`default_nettype wire

// *** sim/scmfc_serial_peer.sv ***
`timescale 1ns/10ps
`default_nettype none
// ********************************
// Far-side serial clock source
// ********************************
module scmfc_serial_peer (
  input wire logic run,
  output logic clk_out,
  output logic clk_en
);
  // The clock stands still outside a run so the block never sees a stray edge.
  initial begin
    clk_out = 1'b1;
    clk_en = 1'b0;
    #37;
    forever begin
      wait (run === 1'b1);
      // The offset keeps pin edges away from the sampling edge of the block's clock.
      #13;
      clk_en = 1'b1;
      while (run === 1'b1) begin
        #200 clk_out = 1'b0;
        #200 clk_out = 1'b1;
      end
      clk_en = 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** sim/tb_serial_mode_format_clock_select.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_serial_mode_format_clock_select;
  import scmfc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [4:0] awa = 5'h00;
  logic [4:0] ara = 5'h00;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic bre = 1'b0;
  logic arv = 1'b0;
  logic rre = 1'b0;
  logic [31:0] wd = 32'h00000000;
  logic [3:0] rx = 4'h0;
  logic run = 1'b0;
  logic cen = 1'b1;
  logic awr, wr, bv, arr, rv, sdrv, sen, irq, fsync, fpar, fmpb, t16, btk, pclk, pen, sprev;
  logic [1:0] br, rr, fstop;
  logic [31:0] rd;
  logic [3:0] fbits;
  wire sck = sen ? sdrv : (pen ? pclk : 1'b1);
  int n_mismatch = 0;
  int n_checks = 0;

  always #25 aclk = ~aclk;
  always @(posedge aclk) sprev <= sdrv;

  scmfc_top uut (.aclk(aclk), .aresetn(aresetn), .ce(cen), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
    .sck_pin(sck), .sck_drive(sdrv), .sck_drive_en(sen), .rx_overrun(rx[EV_OVR]), .rx_framing(rx[EV_FRM]),
    .rx_parity(rx[EV_PAR]), .rx_break(rx[EV_BRK]), .irq(irq), .fmt_sync(fsync), .fmt_data_bits(fbits),
    .fmt_parity(fpar), .fmt_mpb(fmpb), .fmt_stop_bits(fstop), .tick16(t16), .bit_tick(btk));
  scmfc_serial_peer peer (.run(run), .clk_out(pclk), .clk_en(pen));

  // ********************************
  // Shared helpers
  // ********************************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic final_report();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic axw(input logic [4:0] a, input logic [7:0] d);
    logic ad;
    logic dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge aclk);
    awa <= a;
    wd <= {24'h000000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    do begin
      @(posedge aclk);
      if (!ad && awr === 1'b1) begin
        ad = 1'b1;
        awv <= 1'b0;
      end
      if (!dd && wr === 1'b1) begin
        dd = 1'b1;
        wv <= 1'b0;
      end
    end while (!ad || !dd);
    do @(posedge aclk); while (bv !== 1'b1);
    bre <= 1'b0;
    chk("bresp", {30'h0, RESP_OKAY}, {30'h0, br});
  endtask

  task automatic axr(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do @(posedge aclk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge aclk); while (rv !== 1'b1);
    rre <= 1'b0;
    chk("rdata", e, rd);
    chk("rresp", {30'h0, er}, {30'h0, rr});
  endtask

  task automatic pulse(input logic [3:0] v);
    @(posedge aclk);
    rx <= v;
    @(posedge aclk);
    rx <= 4'h0;
    repeat (2) @(posedge aclk);
  endtask

  // Waits for one pulse of the chosen source, then counts cycles to the next one.
  task automatic gap(input int sel, output int n);
    logic p;
    n = 0;
    do begin
      @(posedge aclk);
      p = (sel == 0) ? t16 : (sel == 1) ? btk : (sdrv & ~sprev);
    end while (p !== 1'b1);
    do begin
      @(posedge aclk);
      n++;
      p = (sel == 0) ? t16 : (sel == 1) ? btk : (sdrv & ~sprev);
    end while (p !== 1'b1 && n < 400);
  endtask

  // ********************************
  // Scenarios
  // ********************************
  task automatic t_reset();
    axr(OFF_MODE, 32'h0, RESP_OKAY);
    axr(OFF_CTRL, 32'h0, RESP_OKAY);
    axr(OFF_DIV, {24'h0, DIV_RST}, RESP_OKAY);
    axr(5'h1c, 32'h0, RESP_SLVERR);
    axr(OFF_CLR, 32'h0, RESP_OKAY);
    axr(OFF_FMT, {22'h0, 1'b0, 1'b0, 1'b0, 1'b0, STOP1, DATA8}, RESP_OKAY);
    chk("fmt", {23'h0, 1'b0, DATA8, 1'b0, 1'b0, STOP1}, {23'h0, fsync, fbits, fpar, fmpb, fstop});
    chk("drive_en", 32'h0, {31'h0, sen});
  endtask

  task automatic t_format();
    logic [4:0] k;
    logic [3:0] eb;
    logic [1:0] es;
    for (int i = 0; i < 32; i++) begin
      k = i[4:0];
      axw(OFF_MODE, {k[4], k[3], k[2], 1'b0, k[1], k[0], 2'b00});
      eb = (k[4] || !k[3]) ? DATA8 : DATA7;
      es = k[4] ? STOP0 : (k[1] ? STOP2 : STOP1);
      // The format outputs follow the mode register one edge later.
      @(posedge aclk);
      chk("fmt", {23'h0, k[4], eb, k[2] & ~k[0] & ~k[4], k[0] & ~k[4], es},
          {23'h0, fsync, fbits, fpar, fmpb, fstop});
    end
  endtask

  task automatic t_events();
    axw(OFF_CTRL, 8'h00);
    axw(OFF_MODE, 8'h20);
    axw(OFF_IEN, 8'h00);
    pulse(4'hf);
    axr(OFF_STAT, 32'h0000000f, RESP_OKAY);
    chk("irq_masked", 32'h0, {31'h0, irq});
    axw(OFF_IEN, 8'h02);
    chk("irq_on", 32'h1, {31'h0, irq});
    axw(OFF_CLR, 8'h0f);
    axr(OFF_STAT, 32'h0, RESP_OKAY);
    chk("irq_off", 32'h0, {31'h0, irq});
    axw(OFF_MODE, 8'h00);
    pulse(4'h4);
    axr(OFF_STAT, 32'h0, RESP_OKAY);
    // A framing event in the very cycle of its clear must survive.
    fork
      axw(OFF_CLR, 8'h02);
      begin
        @(posedge aclk);
        rx <= 4'h2;
        @(posedge aclk);
        rx <= 4'h0;
      end
    join
    axr(OFF_STAT, 32'h00000002, RESP_OKAY);
    axw(OFF_CLR, 8'h02);
    axw(OFF_MODE, 8'hac);
    pulse(4'hf);
    axr(OFF_STAT, 32'h00000001, RESP_OKAY);
    axw(OFF_CLR, 8'h0f);
  endtask

  // An event that arrives while the clock enable is low is not recorded.
  task automatic t_ce();
    @(posedge aclk);
    cen <= 1'b0;
    pulse(4'h1);
    @(posedge aclk);
    cen <= 1'b1;
    axr(OFF_STAT, 32'h0, RESP_OKAY);
  endtask

  task automatic t_clk(input logic [7:0] m, input logic [1:0] c, input logic r, input logic en,
                       input int sel, input int exp);
    int n;
    axw(OFF_MODE, m);
    axw(OFF_CTRL, {6'h00, c});
    run <= r;
    repeat (40) @(posedge aclk);
    chk("drive_en", {31'h0, en}, {31'h0, sen});
    gap(sel, n);
    chk("interval", exp, n);
    run <= 1'b0;
  endtask

  initial begin
    #(50 * 20000);
    n_mismatch++;
    final_report();
  end

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_format();
    t_events();
    t_ce();
    axw(OFF_DIV, 8'h01);
    t_clk(8'h00, 2'b00, 1'b0, 1'b0, 0, 2);
    t_clk(8'h00, 2'b00, 1'b0, 1'b0, 1, 32);
    t_clk(8'h00, 2'b01, 1'b0, 1'b1, 2, 32);
    t_clk(8'h00, 2'b10, 1'b1, 1'b0, 0, 8);
    t_clk(8'h00, 2'b11, 1'b1, 1'b0, 1, 128);
    t_clk(8'h80, 2'b00, 1'b0, 1'b1, 2, 4);
    t_clk(8'h80, 2'b00, 1'b0, 1'b1, 1, 4);
    t_clk(8'h80, 2'b10, 1'b1, 1'b0, 1, 8);
    t_clk(8'h80, 2'b11, 1'b1, 1'b0, 1, 8);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    final_report();
  end
endmodule
`default_nettype wire
